// [ioch_channel.sv]
/*
  ioch_channel: one i/o channel with active, full, marker and error
  flags, driving and answering the channel pulses.
  assumes link pulses are asynchronous pins, synchronised here.
*/
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
// What this block does
// - function loads word plus parity, sets active and full, sends function pulse only
// - activate sets active flag and sends active pulse
// - disconnect returns channel inactive and sends inactive pulse
// - full flag never set while active flag is clear, save for an input word arriving in a disconnect's cycle
// - output loads word plus parity, sets full, sends full pulse
// - next output word only when channel active and empty
// - input word with full pulse is captured and sets full flag
// - after storing input word, clear full and register, send empty pulse
// - processor may end input early by clearing active with inactive pulse
// - disconnect is allowed after any input word's empty pulse
// - after last output acknowledged, clear active and send inactive pulse
// - function and activate start only when active flag is clear
// - marker flag is a pure software marker with hardware contention resolution; here one register port, so nothing contends, set wins over clear
// - error flag records input parity error and device output errors
// - pulses are about 25 ns wide, aligned to the channel clock
// - inactive reply to a function is recognised at the end of the major cycle in which it arrives
// - each channel holds active, full, marker and error flags
module ioch_channel
  import ioch_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [ioch_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [ioch_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [ioch_pkg::DATA_W-1:0] reg_rdata_o,
  // channel outputs toward the peripheral equipment unit
  output logic [ioch_pkg::WORD_W-1:0] ch_data_o,
  output logic ch_parity_o,
  output logic ch_data_oe_o,
  output logic ch_function_o,
  output logic ch_active_o,
  output logic ch_inactive_o,
  output logic ch_full_o,
  output logic ch_empty_o,
  // channel inputs from the peripheral equipment unit
  input wire logic [ioch_pkg::WORD_W-1:0] ch_data_i,
  input wire logic ch_parity_i,
  input wire logic ch_inactive_i,
  input wire logic ch_full_i,
  input wire logic ch_empty_i,
  input wire logic ch_error_i
);
  import ioch_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // parity sense chosen by ctrl, read as each word is loaded or captured
  function automatic logic par_of(input logic [WORD_W-1:0] w, input logic odd);
    par_of = (^w) ^ odd;
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sy1_reg, sy2_reg, sy3_reg;
  logic [WORD_W:0] dsy1_reg, dsy2_reg;
  logic [3:0] sy1_next, sy2_next, sy3_next;
  logic [WORD_W:0] dsy1_next, dsy2_next;
  logic inact_ev, full_ev, empty_ev, err_ev;

  // two flops before any logic, third only for edge detect
  always_comb begin
    sy1_next = {ch_error_i, ch_empty_i, ch_full_i, ch_inactive_i};
    sy2_next = sy1_reg;
    sy3_next = sy2_reg;
    dsy1_next = {ch_parity_i, ch_data_i};
    dsy2_next = dsy1_reg;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sy1_reg <= 4'h0;
      sy2_reg <= 4'h0;
      sy3_reg <= 4'h0;
      dsy1_reg <= 13'h0000;
      dsy2_reg <= 13'h0000;
    end else begin
      sy1_reg <= sy1_next;
      sy2_reg <= sy2_next;
      sy3_reg <= sy3_next;
      dsy1_reg <= dsy1_next;
      dsy2_reg <= dsy2_next;
    end
  end

  // rising edges of the incoming pulses
  always_comb begin
    inact_ev = sy2_reg[0] & ~sy3_reg[0];
    full_ev = sy2_reg[1] & ~sy3_reg[1];
    empty_ev = sy2_reg[2] & ~sy3_reg[2];
    err_ev = sy2_reg[3] & ~sy3_reg[3];
  end

  // ----------------------------------------------------------------
  // channel flags, register and pulse generator
  // ----------------------------------------------------------------
  logic active_reg, active_next;
  logic full_reg, full_next;
  logic mark_reg, mark_next;
  logic err_reg, err_next;
  logic dir_in_reg, dir_in_next; // data register holds an input word
  logic func_reg, func_next; // function outstanding
  logic freply_reg, freply_next; // function reply recognised
  logic inact_seen_reg, inact_seen_next;
  logic [4:0] maj_reg, maj_next;
  logic [WORD_W:0] creg_reg, creg_next;
  logic [WORD_W:0] wstage_reg, wstage_next;
  logic [1:0] ctrl_reg, ctrl_next;
  ioch_pulse_type pst_reg, pst_next;
  logic [4:0] pcnt_reg, pcnt_next;
  logic [4:0] pkind_reg, pkind_next; // function, active, inactive, full, empty
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic wr_cmd;
  logic [7:0] cmd;
  logic [4:0] fire;

  always_comb begin
    wr_cmd = reg_wr_i && (reg_addr_i == OFF_CMD);
    cmd = wr_cmd ? reg_wdata_i[7:0] : 8'h00;
  end

  always_comb begin
    active_next = active_reg;
    full_next = full_reg;
    mark_next = mark_reg;
    err_next = err_reg;
    dir_in_next = dir_in_reg;
    func_next = func_reg;
    freply_next = freply_reg;
    inact_seen_next = inact_seen_reg;
    maj_next = maj_reg;
    creg_next = creg_reg;
    wstage_next = wstage_reg;
    ctrl_next = ctrl_reg;
    fire = 5'h00;
    // software writes; the staging word's top bit is unused and stays zero
    if (reg_wr_i && reg_addr_i == OFF_WDATA) begin
      wstage_next = {1'b0, reg_wdata_i[WORD_W-1:0]};
    end else if (reg_wr_i && reg_addr_i == OFF_CTRL) begin
      ctrl_next = reg_wdata_i[1:0];
    end
    // software marker, no hardware effect; one port so no contention
    if (cmd[CMD_SETMARK]) begin
      mark_next = 1'b1;
    end else if (cmd[CMD_CLRMARK]) begin
      mark_next = 1'b0;
    end
    if (cmd[CMD_CLRERR]) begin
      err_next = 1'b0;
    end
    // commands: function and activate need an inactive channel
    if (cmd[CMD_FUNC] && !active_reg && pst_reg == IOCH_IDLE) begin
      creg_next = {par_of(wstage_reg[WORD_W-1:0], ctrl_reg[CTRL_ODD]), wstage_reg[WORD_W-1:0]};
      active_next = 1'b1;
      full_next = 1'b1;
      dir_in_next = 1'b0;
      func_next = 1'b1;
      freply_next = 1'b0;
      inact_seen_next = 1'b0;
      maj_next = 5'h00;
      fire = 5'h01;
    end else if (cmd[CMD_ACT] && !active_reg && pst_reg == IOCH_IDLE) begin
      active_next = 1'b1;
      fire = 5'h02;
    end else if (cmd[CMD_DISC] && active_reg && !full_reg && pst_reg == IOCH_IDLE) begin
      active_next = 1'b0;
      creg_next = 13'h0000;
      fire = 5'h04;
    end else if (cmd[CMD_OUT] && active_reg && !full_reg && !func_reg
                 && pst_reg == IOCH_IDLE) begin
      creg_next = {par_of(wstage_reg[WORD_W-1:0], ctrl_reg[CTRL_ODD]), wstage_reg[WORD_W-1:0]};
      full_next = 1'b1;
      dir_in_next = 1'b0;
      fire = 5'h08;
    end else if (cmd[CMD_TAKE] && full_reg && dir_in_reg && pst_reg == IOCH_IDLE) begin
      full_next = 1'b0;
      creg_next = 13'h0000;
      dir_in_next = 1'b0;
      fire = 5'h10;
    end
    // function reply paced in whole major cycles
    if (func_reg) begin
      maj_next = (maj_reg == MAJOR_LAST) ? 5'h00 : maj_reg + 5'h01;
      if (inact_ev) begin
        inact_seen_next = 1'b1;
      end
      if ((inact_ev || inact_seen_reg) && maj_reg == MAJOR_LAST) begin
        active_next = 1'b0;
        full_next = 1'b0;
        creg_next = 13'h0000;
        func_next = 1'b0;
        freply_next = 1'b1;
        inact_seen_next = 1'b0;
      end
    end else if (inact_ev && !fire[0] && !fire[1]) begin
      // a function or activate in the same cycle wins over a stray inactive;
      // full drops too, so an unread input word is abandoned, never taken
      active_next = 1'b0;
      full_next = 1'b0;
    end
    // empty answer to an output word
    if (empty_ev && full_reg && !dir_in_reg && !func_reg) begin
      full_next = 1'b0;
      creg_next = 13'h0000;
    end
    // input word only lands on an active, empty channel; one that races
    // an inactive pulse is dropped; one that races a disconnect still sets full
    if (full_ev && active_reg && !full_reg && !func_reg && !inact_ev) begin
      creg_next = dsy2_reg;
      full_next = 1'b1;
      dir_in_next = 1'b1;
      if (par_of(dsy2_reg[WORD_W-1:0], ctrl_reg[CTRL_ODD]) != dsy2_reg[WORD_W]) begin
        err_next = 1'b1;
      end
    end
    if (err_ev && ctrl_reg[CTRL_OUTERR]) begin
      err_next = 1'b1;
    end
  end

  // pulse shaper: one pulse of about 25 ns at a time
  // function, activate, disconnect, output and take wait for idle, so a busy shaper quietly refuses them
  always_comb begin
    pst_next = pst_reg;
    pcnt_next = pcnt_reg;
    pkind_next = pkind_reg;
    case (pst_reg)
      IOCH_IDLE: begin
        if (fire != 5'h00) begin
          pst_next = IOCH_PULSE;
          pcnt_next = 5'h00;
          pkind_next = fire;
        end
      end
      IOCH_PULSE: begin
        if (pcnt_reg == PULSE_LAST) begin
          pst_next = IOCH_IDLE;
          pkind_next = 5'h00;
        end else begin
          pcnt_next = pcnt_reg + 5'h01;
        end
      end
      default: begin
        pst_next = IOCH_IDLE;
      end
    endcase
  end

  // read mux, data one cycle after the strobe
  always_comb begin
    rdata_next = 16'h0000;
    if (reg_rd_i) begin
      if (reg_addr_i == OFF_RDATA) begin
        rdata_next = {3'h0, creg_reg};
      end else if (reg_addr_i == OFF_STATUS) begin
        rdata_next[ST_ACTIVE] = active_reg;
        rdata_next[ST_FULL] = full_reg;
        rdata_next[ST_MARK] = mark_reg;
        rdata_next[ST_ERR] = err_reg;
        rdata_next[ST_INWORD] = dir_in_reg;
        rdata_next[ST_FREPLY] = freply_reg;
      end else if (reg_addr_i == OFF_WDATA) begin
        rdata_next = {4'h0, wstage_reg[WORD_W-1:0]};
      end else if (reg_addr_i == OFF_CTRL) begin
        rdata_next = {14'h0000, ctrl_reg};
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      active_reg <= 1'b0;
      full_reg <= 1'b0;
      mark_reg <= 1'b0;
      err_reg <= 1'b0;
      dir_in_reg <= 1'b0;
      func_reg <= 1'b0;
      freply_reg <= 1'b0;
      inact_seen_reg <= 1'b0;
      maj_reg <= 5'h00;
      creg_reg <= 13'h0000;
      wstage_reg <= 13'h0000;
      ctrl_reg <= CTRL_RESET;
      pst_reg <= IOCH_IDLE;
      pcnt_reg <= 5'h00;
      pkind_reg <= 5'h00;
      rdata_reg <= 16'h0000;
    end else begin
      active_reg <= active_next;
      full_reg <= full_next;
      mark_reg <= mark_next;
      err_reg <= err_next;
      dir_in_reg <= dir_in_next;
      func_reg <= func_next;
      freply_reg <= freply_next;
      inact_seen_reg <= inact_seen_next;
      maj_reg <= maj_next;
      creg_reg <= creg_next;
      wstage_reg <= wstage_next;
      ctrl_reg <= ctrl_next;
      pst_reg <= pst_next;
      pcnt_reg <= pcnt_next;
      pkind_reg <= pkind_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  // data lines are driven only while the register holds an outgoing word
  always_comb begin
    reg_rdata_o = rdata_reg;
    ch_data_o = creg_reg[WORD_W-1:0];
    ch_parity_o = creg_reg[WORD_W];
    ch_data_oe_o = full_reg & ~dir_in_reg;
    ch_function_o = pkind_reg[0];
    ch_active_o = pkind_reg[1];
    ch_inactive_o = pkind_reg[2];
    ch_full_o = pkind_reg[3];
    ch_empty_o = pkind_reg[4];
  end
endmodule

// [ioch_channel_checker.sv]
/*
  ioch_channel_checker: port-level assertions for one i/o channel.
  assumes it is bound to ioch_channel and sees only its ports.
*/
`timescale 1ns/10ps
module ioch_channel_checker
  import ioch_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // watched ports
  input wire logic reg_rd_i,
  input wire logic [ioch_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic [ioch_pkg::WORD_W-1:0] ch_data_o,
  input wire logic ch_parity_o,
  input wire logic ch_data_oe_o,
  input wire logic ch_function_o,
  input wire logic ch_active_o,
  input wire logic ch_inactive_o,
  input wire logic ch_full_o,
  input wire logic ch_empty_o,
  input wire logic ch_empty_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // function pulse goes out alone, with the word held
  property p_fn_quiet;
    $rose(ch_function_o) |-> ch_data_oe_o && !ch_active_o && !ch_full_o;
  endproperty
  a_fn_quiet: assert property (p_fn_quiet) else $error("function pulse not alone");
  // an early reply must not have dropped the function word 20 cycles after the function pulse
  property p_fn_hold;
    $rose(ch_function_o) |-> ##20 ch_data_oe_o;
  endproperty
  a_fn_hold: assert property (p_fn_hold) else $error("function word dropped early");
  property p_pw_full;
    $rose(ch_full_o) |-> ch_full_o [*3] ##1 !ch_full_o;
  endproperty
  a_pw_full: assert property (p_pw_full) else $error("full pulse width wrong");
  property p_pw_inact;
    $rose(ch_inactive_o) |-> ##3 $fell(ch_inactive_o);
  endproperty
  a_pw_inact: assert property (p_pw_inact) else $error("inactive pulse width wrong");
  property p_out_word;
    ch_full_o |-> ch_data_oe_o;
  endproperty
  a_out_word: assert property (p_out_word) else $error("full pulse without word");
  // sync delay of the answer is three edges, so a short window suffices
  property p_empty_ack;
    $rose(ch_empty_i) && ch_data_oe_o && !ch_function_o |-> ##[1:6] !ch_data_oe_o;
  endproperty
  a_empty_ack: assert property (p_empty_ack) else $error("empty answer not applied");
  property p_take_empty;
    $rose(ch_empty_o) |-> !ch_data_oe_o && ch_data_o == '0 && !ch_parity_o;
  endproperty
  a_take_empty: assert property (p_take_empty) else $error("empty pulse with word held");
  property p_act;
    $rose(ch_active_o) |-> !ch_data_oe_o && !ch_function_o;
  endproperty
  a_act: assert property (p_act) else $error("active pulse on busy channel");
  property p_rdata;
    !$past(reg_rd_i) |-> reg_rdata_o == '0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
  c_fn: cover property ($rose(ch_function_o));
  c_out: cover property ($rose(ch_full_o));
  c_take: cover property ($rose(ch_empty_o));
endmodule

bind ioch_channel ioch_channel_checker ioch_channel_checker_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ch_data_o(ch_data_o), .ch_parity_o(ch_parity_o),
  .ch_data_oe_o(ch_data_oe_o), .ch_function_o(ch_function_o),
  .ch_active_o(ch_active_o), .ch_inactive_o(ch_inactive_o), .ch_full_o(ch_full_o), .ch_empty_o(ch_empty_o),
  .ch_empty_i(ch_empty_i));

// [ioch_peu_model.sv]
/*
  ioch_peu_model: behavioural peripheral equipment unit.
  assumes channel pulses are registered on core_clk_i.
*/
`timescale 1ns/10ps
module ioch_peu_model
  import ioch_pkg::*;
(
  // clock
  input wire logic core_clk_i,
  // from the channel
  input wire logic [ioch_pkg::WORD_W-1:0] ch_data_o,
  input wire logic ch_parity_o,
  input wire logic ch_function_o,
  input wire logic ch_active_o,
  input wire logic ch_inactive_o,
  input wire logic ch_full_o,
  input wire logic ch_empty_o,
  // toward the channel
  output logic [ioch_pkg::WORD_W-1:0] ch_data_i,
  output logic ch_parity_i,
  output logic ch_inactive_i,
  output logic ch_full_i,
  output logic ch_empty_i,
  output logic ch_error_i
);
  logic [3:0] pl = 4'h0; // inactive, full, empty, error
  // answer lands dly+1 clocks after the pulse: 39 is about 310 ns, each
  // further 12 or 13 clocks is one 100 ns step for slower answers
  int dly = 38;
  int n_fn = 0, n_act = 0, n_inact = 0, n_out = 0, n_emp = 0;
  logic [12:0] fn_word, out_word;
  assign ch_inactive_i = pl[0];
  assign ch_full_i = pl[1];
  assign ch_empty_i = pl[2];
  assign ch_error_i = pl[3];
  initial begin
    ch_data_i = 12'h000;
    ch_parity_i = 1'b0;
  end
  // three clocks wide, launched just after an edge
  task automatic pulse(input int k);
    @(posedge core_clk_i);
    pl[k] <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    pl[k] <= 1'b0;
  endtask
  // function word sampled as a code and answered by inactive
  always @(posedge ch_function_o) begin
    #1;
    n_fn++;
    fn_word = {ch_parity_o, ch_data_o};
    repeat (dly) @(posedge core_clk_i);
    pulse(0);
  end
  // output word taken and answered by empty
  always @(posedge ch_full_o) begin
    #1;
    n_out++;
    out_word = {ch_parity_o, ch_data_o};
    repeat (dly) @(posedge core_clk_i);
    pulse(2);
  end
  always @(posedge ch_active_o) n_act++;
  // dropped at once: lines released show the inverse, no stale word
  always @(posedge ch_inactive_o) begin
    n_inact++;
    ch_data_i <= ~ch_data_i;
  end
  always @(posedge ch_empty_o) n_emp++;
  task automatic send_word(input logic [11:0] w, input logic p);
    @(posedge core_clk_i);
    ch_data_i <= w;
    ch_parity_i <= p;
    pulse(1);
    repeat (4) @(posedge core_clk_i);
    ch_data_i <= ~w;
    ch_parity_i <= ~p;
  endtask
  task automatic end_input;
    pulse(0);
  endtask
endmodule

// [ioch_pkg.sv]
/*
  ioch_pkg: constants for the parallel i/o channel handshake block.
  assumes a 125 mhz core clock and a plain strobe register port.
*/
package ioch_pkg;
  // ----------------------------------------------------------------
  // word and register map
  // ----------------------------------------------------------------
  localparam int WORD_W = 12;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] OFF_CMD = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_WDATA = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_RDATA = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h4;
  // command register bits (write one to start)
  localparam int CMD_FUNC = 0;
  localparam int CMD_ACT = 1;
  localparam int CMD_DISC = 2;
  localparam int CMD_OUT = 3;
  localparam int CMD_TAKE = 4;
  localparam int CMD_CLRERR = 5;
  localparam int CMD_SETMARK = 6;
  localparam int CMD_CLRMARK = 7;
  // status register bits
  localparam int ST_ACTIVE = 0;
  localparam int ST_FULL = 1;
  localparam int ST_MARK = 2;
  localparam int ST_ERR = 3;
  localparam int ST_INWORD = 4;
  localparam int ST_FREPLY = 5;
  // control register bits
  localparam int CTRL_ODD = 0;
  localparam int CTRL_OUTERR = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PS = 8000;
  localparam int PULSE_NS = 25;
  localparam int MAJOR_NS = 250;
  localparam int PULSE_CYC = (PULSE_NS * 1000) / CLK_PS;
  localparam int MAJOR_CYC = (MAJOR_NS * 1000) / CLK_PS;
  localparam logic [4:0] PULSE_LAST = 5'(PULSE_CYC - 1);
  localparam logic [4:0] MAJOR_LAST = 5'(MAJOR_CYC - 1);
  typedef enum logic [1:0] {
    IOCH_IDLE = 2'b00,
    IOCH_PULSE = 2'b01
  } ioch_pulse_type;
endpackage

// [tb_ioch_channel.sv]
/*
  tb_ioch_channel: self-checking bench for one channel.
  assumes the peu model answers every function and output word.
*/
`timescale 1ns/10ps
module tb_ioch_channel;
  import ioch_pkg::*;
  typedef struct {logic [11:0] w; logic p; int d;} ioch_row_type;
  ioch_row_type rows [5] = '{'{12'h000, 1'b1, 38}, '{12'hfff, 1'b1, 38}, '{12'h001, 1'b0, 51},
    '{12'ha5c, 1'b1, 38}, '{12'h7ff, 1'b0, 63}};
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [DATA_W-1:0] reg_rdata_o, v;
  logic [WORD_W-1:0] ch_data_o, ch_data_i;
  logic ch_parity_o, ch_data_oe_o, ch_function_o, ch_active_o, ch_inactive_o, ch_full_o, ch_empty_o;
  logic ch_parity_i, ch_inactive_i, ch_full_i, ch_empty_i, ch_error_i;
  int bad_count = 0;
  int n_tests = 0;
  always #4 core_clk_i = ~core_clk_i;
  ioch_channel ioch_channel_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .ch_data_o(ch_data_o), .ch_parity_o(ch_parity_o), .ch_data_oe_o(ch_data_oe_o), .ch_function_o(ch_function_o),
    .ch_active_o(ch_active_o), .ch_inactive_o(ch_inactive_o), .ch_full_o(ch_full_o), .ch_empty_o(ch_empty_o),
    .ch_data_i(ch_data_i), .ch_parity_i(ch_parity_i), .ch_inactive_i(ch_inactive_i), .ch_full_i(ch_full_i),
    .ch_empty_i(ch_empty_i), .ch_error_i(ch_error_i));
  ioch_peu_model ioch_peu_model_i (.core_clk_i(core_clk_i), .ch_data_o(ch_data_o), .ch_parity_o(ch_parity_o),
    .ch_function_o(ch_function_o), .ch_active_o(ch_active_o), .ch_inactive_o(ch_inactive_o), .ch_full_o(ch_full_o),
    .ch_empty_o(ch_empty_o), .ch_data_i(ch_data_i), .ch_parity_i(ch_parity_i), .ch_inactive_i(ch_inactive_i),
    .ch_full_i(ch_full_i), .ch_empty_i(ch_empty_i), .ch_error_i(ch_error_i));
  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected value at %0t: %h instead of %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    // one idle edge, so the next call never reassigns the strobe in this step
    @(posedge core_clk_i);
  endtask
  // data stands only in the cycle after the strobe
  task rd(input logic [3:0] a);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge core_clk_i);
    v = reg_rdata_o;
    @(posedge core_clk_i);
  endtask
  // pulse commands are refused while a pulse runs, so let it finish
  task cmd(input int b);
    wr(OFF_CMD, 16'(1 << b));
    repeat (4) @(posedge core_clk_i);
  endtask
  task st(input int b, input logic e);
    rd(OFF_STATUS);
    chk({15'h0, v[b]}, {15'h0, e});
  endtask
  task wait_st(input int b, input logic e);
    for (int i = 0; i < 300; i++) begin
      rd(OFF_STATUS);
      if (v[b] === e) return;
    end
    bad_count++;
    print_verdict;
  endtask
  initial begin
    repeat (50000) @(posedge core_clk_i);
    bad_count++;
    print_verdict;
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    rd(OFF_STATUS); chk(v, 16'h0000);
    rd(OFF_CTRL); chk(v, 16'h0001);
    rd(4'hf); chk(v, 16'h0000);
    // function: both flags up, no active or full pulse, reply clears
    wr(OFF_WDATA, 16'h0123);
    cmd(CMD_FUNC);
    rd(OFF_STATUS); chk(v & 16'h0003, 16'h0003);
    wait_st(ST_ACTIVE, 1'b0);
    st(ST_FULL, 1'b0);
    st(ST_FREPLY, 1'b1);
    chk({3'h0, ioch_peu_model_i.fn_word}, 16'h1123);
    chk(16'(ioch_peu_model_i.n_act + ioch_peu_model_i.n_out), 16'h0);
    cmd(CMD_ACT);
    st(ST_ACTIVE, 1'b1);
    chk(16'(ioch_peu_model_i.n_act), 16'h1);
    // function and activate on an active channel are refused
    cmd(CMD_FUNC);
    cmd(CMD_ACT);
    chk(16'(ioch_peu_model_i.n_fn + ioch_peu_model_i.n_act), 16'h2);
    // output rows, a second back-to-back output must be refused
    foreach (rows[i]) begin
      ioch_peu_model_i.dly = rows[i].d;
      wr(OFF_WDATA, {4'h0, rows[i].w});
      wr(OFF_CMD, 16'h0008);
      wr(OFF_CMD, 16'h0008);
      wait_st(ST_FULL, 1'b0);
      chk({3'h0, ioch_peu_model_i.out_word}, {3'h0, rows[i].p, rows[i].w});
      chk(16'(ioch_peu_model_i.n_out), 16'(i + 1));
    end
    cmd(CMD_DISC);
    st(ST_ACTIVE, 1'b0);
    chk(16'(ioch_peu_model_i.n_inact), 16'h1);
    // a word offered to an inactive channel is ignored
    ioch_peu_model_i.send_word(12'h456, 1'b0);
    st(ST_FULL, 1'b0);
    // two input words, the second with a parity fault
    cmd(CMD_ACT);
    for (int k = 0; k < 2; k++) begin
      ioch_peu_model_i.send_word(12'h456, k[0]);
      wait_st(ST_INWORD, 1'b1);
      rd(OFF_RDATA); chk(v, {3'h0, k[0], 12'h456});
      st(ST_ERR, k[0]);
      cmd(CMD_TAKE);
      st(ST_FULL, 1'b0);
      chk(16'(ioch_peu_model_i.n_emp), 16'(k + 1));
    end
    cmd(CMD_CLRERR);
    st(ST_ERR, 1'b0);
    // device error line counts only when enabled; even parity on output
    ioch_peu_model_i.pulse(3);
    st(ST_ERR, 1'b0);
    wr(OFF_CTRL, 16'h0002);
    ioch_peu_model_i.pulse(3);
    wait_st(ST_ERR, 1'b1);
    cmd(CMD_CLRERR);
    wr(OFF_WDATA, 16'h0001);
    cmd(CMD_OUT);
    wait_st(ST_FULL, 1'b0);
    chk({3'h0, ioch_peu_model_i.out_word}, 16'h1001);
    wr(OFF_CTRL, 16'h0001);
    cmd(CMD_DISC);
    st(ST_ACTIVE, 1'b0);
    chk(16'(ioch_peu_model_i.n_inact), 16'h2);
    cmd(CMD_ACT);
    ioch_peu_model_i.end_input();
    wait_st(ST_ACTIVE, 1'b0);
    cmd(CMD_SETMARK);
    st(ST_MARK, 1'b1);
    cmd(CMD_CLRMARK);
    st(ST_MARK, 1'b0);
    print_verdict;
  end
endmodule
